// ### shared/cfg_access_pkg.sv
/*
 Constants for the host configuration port and the embedded controller's
 direct window onto configuration frames.
 Assumes one 200 MHz clock and an active-low asynchronous reset.
*/
package cfg_access_pkg;
    localparam logic [7:0]  KEY_ENTER      = 8'h55;
    localparam logic [7:0]  KEY_EXIT       = 8'haa;
    localparam logic [0:0]  PORT_KEY_INDEX = 1'h0;
    localparam logic [0:0]  PORT_DATA      = 1'h1;
    localparam logic [7:0]  IDX_DEV_NUMBER = 8'h07;
    localparam logic [7:0]  IDX_GLOBAL_TOP = 8'h2f;
    localparam logic [7:0]  READ_UNDEF     = 8'hff;
    localparam logic [7:0]  INDEX_RESET    = 8'h00;
    localparam logic [5:0]  DEV_RESET      = 6'h00;
    localparam logic [1:0]  QUAD_CONFIG    = 2'h3;
    localparam logic [7:0]  SPACE_BASE     = 8'hff;
    localparam logic [7:0]  SPACE_COMP     = 8'hfe;
    localparam logic [5:0]  DEV_MAILBOX    = 6'h00;
    localparam logic [5:0]  DEV_KBC        = 6'h01;
    localparam logic [5:0]  DEV_ACPI0      = 6'h02;
    localparam logic [5:0]  DEV_ACPI3      = 6'h05;
    localparam logic [5:0]  DEV_PM1        = 6'h06;
    localparam logic [5:0]  DEV_UART       = 6'h07;
    localparam logic [5:0]  DEV_FAST_KB    = 6'h08;
    localparam logic [5:0]  DEV_LPC        = 6'h0c;
    localparam logic [5:0]  DEV_COMP_BUS   = 6'h0d;
    localparam logic [5:0]  DEV_FLASH      = 6'h0e;
    localparam logic [5:0]  DEV_FLASH_SPI  = 6'h0f;
    localparam logic [5:0]  DEV_SHARED_MEM = 6'h10;
    localparam logic [5:0]  DEV_GLOBAL     = 6'h3f;
    localparam logic [23:0] LPC_CFG_LO     = 24'hff3300;
    localparam logic [23:0] LPC_CFG_HI     = 24'hff33f0;
    localparam logic [23:0] BAR_CFGPORT    = 24'hff3360;
    localparam logic [23:0] BAR_GLOBAL     = 24'hff3384;
    localparam logic [4:0]  COMP_DEV_MAX   = 5'h10;
    localparam logic [15:0] BAR_IO_RESET   = 16'h002e;
    localparam int          BAR_VALID_BIT  = 31;
    localparam logic [1:0]  SZ_BYTE        = 2'h0;
    localparam logic [1:0]  SZ_HALF        = 2'h1;
    localparam logic [1:0]  SZ_WORD        = 2'h2;
    localparam logic [1:0]  RW_8           = 2'h0;
    localparam logic [1:0]  RW_16          = 2'h1;
    localparam logic [1:0]  RW_32          = 2'h2;

    typedef enum logic [0:0] {
        ST_RUN    = 1'b0,
        ST_CONFIG = 1'b1
    } cfg_state_e;
endpackage

// ### src/frame_decode.sv
/*
 Decodes a 24-bit controller address into configuration frame fields and
 checks the transfer width against the target register width.
 Assumes purely combinational use by the access block.
*/
`timescale 1ns/1ps
module frame_decode (
    input  wire logic [23:0] addr,
    input  wire logic [1:0]  size,
    input  wire logic [1:0]  reg_width,
    output logic             is_cfg,
    output logic             is_comp,
    output logic [5:0]       dev,
    output logic [7:0]       index,
    output logic             size_ok
);
    always_comb begin
        // Basechip and companion spaces; companions only hold 16 frames each
        is_comp = (addr[23:16] == cfg_access_pkg::SPACE_COMP)
                  && (addr[15:14] == 2'h0);
        is_cfg  = ((addr[23:16] == cfg_access_pkg::SPACE_BASE) || is_comp)
                  && (addr[9:8] == cfg_access_pkg::QUAD_CONFIG);
        dev     = addr[15:10];
        index   = addr[7:0];
        unique case (reg_width)
            cfg_access_pkg::RW_16: size_ok = size != cfg_access_pkg::SZ_WORD;
            cfg_access_pkg::RW_32: size_ok = 1'b1;
            default:               size_ok = size == cfg_access_pkg::SZ_BYTE;
        endcase
    end
endmodule // frame_decode

// ### src/logical_device_config_access.sv
/*
 Host configuration port (key, index, data) and the controller's direct
 path to the configuration frames. Register contents live downstream on
 the cfg_* request port, which answers in the same cycle, except the device number and the port and global base registers, held here.
 Assumes host I/O strobes already synchronous to ref_clk, one per access.
*/
`timescale 1ns/1ps
module logical_device_config_access (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Host byte I/O cycles
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    output logic             io_claim,
    // Embedded controller direct access
    input  wire logic        ec_req,
    input  wire logic        ec_write,
    input  wire logic [23:0] ec_addr,
    input  wire logic [1:0]  ec_size,
    input  wire logic [31:0] ec_wdata,
    output logic [31:0]      ec_rdata,
    output logic             ec_done,
    output logic             ec_error,
    // Configuration register store
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic [23:0]      cfg_addr,
    output logic [1:0]       cfg_size,
    output logic [31:0]      cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_defined,
    input  wire logic [1:0]  cfg_width,
    output logic             in_config
);
    typedef struct packed {
        cfg_access_pkg::cfg_state_e state;
        logic [7:0]                 index;
        logic [5:0]                 dev;
        logic [31:0]                bar_port;
        logic                       global_valid;
        logic [7:0]                 io_rdata;
        logic                       io_claim;
        logic [31:0]                ec_rdata;
        logic                       ec_done;
        logic                       ec_error;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    logic       ec_cfg;
    logic       ec_comp;
    logic [5:0] ec_dev;
    logic [7:0] ec_idx;
    logic       ec_size_ok;

    ////////////////////////////////////////////////////////////////////////
    frame_decode u_dec (
        .addr      (ec_addr),
        .size      (ec_size),
        .reg_width (cfg_width),
        .is_cfg    (ec_cfg),
        .is_comp   (ec_comp),
        .dev       (ec_dev),
        .index     (ec_idx),
        .size_ok   (ec_size_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    logic        port_hit;
    logic        data_hit;
    logic        host_go;
    logic [5:0]  host_dev;
    logic [23:0] host_addr;
    logic        bar_hit;
    logic        gbar_hit;
    logic        lpc_cfg_hit;
    logic [7:0]  host_lane;

    always_comb begin
        // Port sits wherever software put it; never a fixed decode
        port_hit = st_ff.bar_port[cfg_access_pkg::BAR_VALID_BIT]
                   && (io_addr[15:1] == st_ff.bar_port[15:1]);
        data_hit = io_addr[0] == cfg_access_pkg::PORT_DATA;
        host_go  = port_hit && data_hit
                   && (st_ff.state == cfg_access_pkg::ST_CONFIG);
        // Low indices other than 07h always reach the global frame
        host_dev = (st_ff.index <= cfg_access_pkg::IDX_GLOBAL_TOP)
                   ? cfg_access_pkg::DEV_GLOBAL : st_ff.dev;
        // Host byte lands in the configuration quadrant of its frame
        host_addr = {cfg_access_pkg::SPACE_BASE, host_dev,
                     cfg_access_pkg::QUAD_CONFIG, st_ff.index};
        // Store steers bytes by lane, so pick the lane the index names
        host_lane = cfg_rdata[8 * st_ff.index[1:0] +: 8];
        bar_hit  = ec_addr == cfg_access_pkg::BAR_CFGPORT;
        gbar_hit = ec_addr == cfg_access_pkg::BAR_GLOBAL;
        lpc_cfg_hit = (ec_addr >= cfg_access_pkg::LPC_CFG_LO)
                      && (ec_addr <= cfg_access_pkg::LPC_CFG_HI);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.io_claim = 1'b0;
        nxt_st.ec_done  = 1'b0;
        nxt_st.ec_error = 1'b0;
        cfg_wr    = 1'b0;
        cfg_rd    = 1'b0;
        cfg_addr  = host_addr;
        cfg_size  = cfg_access_pkg::SZ_BYTE;
        // Host byte on every lane; the store keeps only the addressed one
        cfg_wdata = {4{io_wdata}};

        // Host side owns the store when its cycle hits the port; controller request is dropped
        if ((io_wr || io_rd) && port_hit) begin
            nxt_st.io_claim = 1'b1;
            if (!data_hit) begin
                if (io_wr) begin
                    if (io_wdata == cfg_access_pkg::KEY_ENTER &&
                        st_ff.state == cfg_access_pkg::ST_RUN) begin
                        nxt_st.state = cfg_access_pkg::ST_CONFIG;
                        nxt_st.index = cfg_access_pkg::INDEX_RESET;
                    end else if (io_wdata == cfg_access_pkg::KEY_EXIT) begin
                        nxt_st.state = cfg_access_pkg::ST_RUN;
                    end else if (st_ff.state == cfg_access_pkg::ST_CONFIG) begin
                        nxt_st.index = io_wdata;
                    end
                end else begin
                    nxt_st.io_rdata = (st_ff.state == cfg_access_pkg::ST_CONFIG)
                                      ? st_ff.index
                                      : cfg_access_pkg::READ_UNDEF;
                end
            end else if (host_go) begin
                if (st_ff.index == cfg_access_pkg::IDX_DEV_NUMBER) begin
                    // Selector held locally so the host path needs no lookup
                    if (io_wr)
                        nxt_st.dev = io_wdata[5:0];
                    else
                        nxt_st.io_rdata = {2'h0, st_ff.dev};
                end else begin
                    cfg_wr = io_wr && cfg_defined;
                    cfg_rd = io_rd;
                    if (io_rd)
                        nxt_st.io_rdata = cfg_defined ? host_lane
                                          : cfg_access_pkg::READ_UNDEF;
                end
            end else if (io_rd) begin
                nxt_st.io_rdata = cfg_access_pkg::READ_UNDEF;
            end
        end else if (ec_req) begin
            // Controller never sees the port; only frame addresses
            nxt_st.ec_done = 1'b1;
            cfg_addr  = ec_addr;
            cfg_size  = ec_size;
            cfg_wdata = ec_wdata;
            if (bar_hit) begin
                if (ec_write)
                    nxt_st.bar_port = ec_wdata;
                else
                    nxt_st.ec_rdata = st_ff.bar_port;
            end else if (gbar_hit) begin
                if (ec_write)
                    nxt_st.global_valid =
                        ec_wdata[cfg_access_pkg::BAR_VALID_BIT];
                else
                    nxt_st.ec_rdata = {st_ff.global_valid, 31'h0};
            end else if ((ec_cfg || ec_comp || lpc_cfg_hit)
                         && ec_size_ok && cfg_defined) begin
                cfg_wr = ec_write;
                cfg_rd = !ec_write;
                if (!ec_write)
                    nxt_st.ec_rdata = cfg_rdata;
            end else begin
                nxt_st.ec_error = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            // Run state and cleared index from reset
            st_ff <= '{state:        cfg_access_pkg::ST_RUN,
                       index:        cfg_access_pkg::INDEX_RESET,
                       dev:          cfg_access_pkg::DEV_RESET,
                       bar_port:     {1'b1, 15'h0, cfg_access_pkg::BAR_IO_RESET},
                       global_valid: 1'b0,
                       io_rdata:     8'h00,
                       io_claim:     1'b0,
                       ec_rdata:     32'h0,
                       ec_done:      1'b0,
                       ec_error:     1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign io_rdata  = st_ff.io_rdata;
    assign io_claim  = st_ff.io_claim;
    assign ec_rdata  = st_ff.ec_rdata;
    assign ec_done   = st_ff.ec_done;
    assign ec_error  = st_ff.ec_error;
    assign in_config = st_ff.state == cfg_access_pkg::ST_CONFIG;
endmodule // logical_device_config_access

// ### tb/cfg_access_monitor.sv
/*
 Port checker for the configuration access block.
 Assumes it is bound to every instance of that block.
*/
`timescale 1ns/1ps
module cfg_access_monitor (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_claim,
    input wire logic        ec_req,
    input wire logic        ec_done,
    input wire logic        ec_error,
    input wire logic        cfg_wr,
    input wire logic [23:0] cfg_addr,
    input wire logic        in_config
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////////
// Index write, one idle cycle, then index read at the same place
sequence s_idx_wr_rd;
    in_config && io_wr && !io_addr[0] && io_wdata != 8'haa
    ##1 io_claim && !io_wr && !io_rd
    ##1 io_rd && io_addr == $past(io_addr, 2);
endsequence
AST_IDX_BACK: assert property (s_idx_wr_rd |=>
    io_claim && io_rdata == $past(io_wdata, 3))
    else $error("index read differs from last index written");
AST_ENTER: assert property ($rose(in_config) |->
    $past(io_wr && io_wdata == 8'h55 && !io_addr[0]))
    else $error("config state entered without entry key");
AST_EXIT: assert property ($fell(in_config) |->
    $past(io_wr && io_wdata == 8'haa && !io_addr[0]))
    else $error("config state left without exit key");
AST_RUN_READ: assert property (
    io_claim && $past(io_rd && !in_config) |-> io_rdata == 8'hff)
    else $error("port read in run state not ffh");
AST_HOST_GATE: assert property (
    cfg_wr && io_wr && io_addr[0] |-> in_config)
    else $error("data port reached store in run state");
// Host strobes that hit the port win, so a colliding controller request is dropped
AST_EC_TAKE: assert property (
    ec_req && !io_wr && !io_rd |=> ec_done)
    else $error("controller request not answered");
AST_EC_CAUSE: assert property (
    ec_done |-> $past(ec_req && !io_wr && !io_rd))
    else $error("controller done without a taken request");
AST_EC_ERR: assert property (ec_error |-> ec_done)
    else $error("error without done");
AST_QUAD: assert property (cfg_wr |->
    cfg_addr[9:8] == 2'b11 && cfg_addr[23:17] == 7'h7f)
    else $error("store write outside configuration quadrant");
endmodule // cfg_access_monitor

bind logical_device_config_access cfg_access_monitor mon (.ref_clk, .nrst,
    .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .io_claim, .ec_req,
    .ec_done, .ec_error, .cfg_wr, .cfg_addr, .in_config);

// ### tb/cfg_store_model.sv
/*
 Register store behind the cfg port: byte memory, lanes steered by address.
 Assumes requests and answers in the same cycle.
*/
`timescale 1ns/1ps
module cfg_store_model (
    input wire logic        ref_clk,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [23:0] cfg_addr,
    input wire logic [1:0]  cfg_size,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0]     cfg_rdata,
    output logic            cfg_defined,
    output logic [1:0]      cfg_width
);
logic [7:0]  mem [0:131071];
logic [16:0] a;
logic [31:0] w;
assign a = {cfg_addr[16:2], 2'b00};
assign w = {mem[a + 3], mem[a + 2], mem[a + 1], mem[a]};
// Idle bus shows the inverse, so a stale read cannot pass by luck
assign cfg_rdata = cfg_rd ? w : ~w;
assign cfg_defined = cfg_addr[7:0] < 8'hf0;
assign cfg_width = cfg_addr[7:4] == 4'h4 ? 2'h0 :
                   cfg_addr[7:4] == 4'h5 ? 2'h1 : 2'h2;
always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
        if (cfg_wr && (cfg_size == 2'h2 || i == cfg_addr[1:0]
            || (cfg_size == 2'h1 && i[1] == cfg_addr[1]))) begin
            mem[a + i] <= cfg_wdata[8 * i +: 8];
        end
    end
end
endmodule // cfg_store_model

// ### tb/tb_top.sv
/*
 Self-checking bench: host byte port, controller access, store model.
 Assumes the port base register resets valid at 002eh.
*/
`timescale 1ns/1ps
module tb_top;
logic        ref_clk = 0, nrst = 0, io_wr = 0, io_rd = 0;
logic        ec_req = 0, ec_write = 0;
logic        io_claim, ec_done, ec_error, cfg_wr, cfg_rd, cfg_defined;
logic        in_config;
logic [15:0] io_addr = 0, base = 16'h002e;
logic [7:0]  io_wdata = 0, io_rdata, q, x, d;
logic [23:0] ec_addr = 0, cfg_addr;
logic [1:0]  ec_size = 0, cfg_size, cfg_width;
logic [31:0] ec_wdata = 0, ec_rdata, cfg_rdata, cfg_wdata, r, w;
logic [24:0] bad [4] = '{25'h1ff3100, 25'h1fd0300, 25'h0fe0300, 25'h1fe4300};
logic [5:0]  devs [15] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h3f};
int          n_errors = 0, tests_run = 0, cyc = 0;
logical_device_config_access uut (.ref_clk, .nrst, .io_wr, .io_rd, .io_addr,
    .io_wdata, .io_rdata, .io_claim, .ec_req, .ec_write, .ec_addr, .ec_size,
    .ec_wdata, .ec_rdata, .ec_done, .ec_error, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_size, .cfg_wdata, .cfg_rdata, .cfg_defined, .cfg_width, .in_config);
cfg_store_model store (.ref_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_size,
    .cfg_wdata, .cfg_rdata, .cfg_defined, .cfg_width);
always #2.5 ref_clk = ~ref_clk;
// The whole run needs well under a thousand cycles
always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
        n_errors++;
        conclude();
    end
end
////////////////////////////////////////////////////////////////////////////
task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
task automatic chk(input logic [31:0] s, e, input string n);
    tests_run++;
    if (s !== e) begin
        n_errors++;
        $display("mismatch %s exp %h seen %h", n, e, s);
    end
endtask
// Byte cycles only; one idle cycle follows each strobe
task automatic io(input logic wr, a, input logic [7:0] wd);
    io_wr = wr;
    io_rd = !wr;
    io_addr = {base[15:1], a};
    io_wdata = wd;
    @(posedge ref_clk) #1;
    io_wr = 0;
    io_rd = 0;
    q = io_rdata;
    chk(io_claim, 1, "io_claim");
    @(posedge ref_clk) #1;
endtask
task automatic ec(input logic wr, input logic [23:0] a, input logic [1:0] s,
                  input logic [31:0] wd, input logic e);
    ec_req = 1;
    ec_write = wr;
    ec_addr = a;
    ec_size = s;
    ec_wdata = wd;
    @(posedge ref_clk) #1;
    ec_req = 0;
    r = ec_rdata;
    chk({ec_done, ec_error}, {1'b1, e}, "ec_status");
    @(posedge ref_clk) #1;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(32'hf2f72537));
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1;
    chk(in_config, 0, "in_config");
    io(0, 0, 8'h00);
    chk(q, 8'hff, "run_index_read");
    io(1, 1, 8'h12);
    io(1, 0, 8'h55);
    chk(in_config, 1, "in_config");
    io(0, 0, 8'h00);
    chk(q, 8'h00, "index_after_entry");
    foreach (devs[k]) begin
        x = 8'h30 + 8'($urandom_range(191));
        // AAh is the exit key; 60h and 84h of device Ch are live base regs
        if (x == 8'haa || (devs[k] == 6'h0c && (x == 8'h60 || x == 8'h84)))
            x++;
        d = 8'($urandom);
        io(1, 0, 8'h07);
        io(1, 1, {2'b00, devs[k]});
        io(1, 0, x);
        io(0, 0, 8'h00);
        chk(q, x, "index_read");
        io(1, 1, d);
        io(0, 1, 8'h00);
        chk(q, d, "data_read");
        ec(0, {8'hff, devs[k], 2'b11, x}, 2'h0, 0, 0);
        chk(r[8 * x[1:0] +: 8], d, "frame_byte");
    end
    io(1, 0, 8'h07);
    io(0, 1, 8'h00);
    chk(q, 8'h3f, "device_number");
    io(1, 0, 8'h20);
    io(1, 1, d);
    ec(0, 24'hffff20, 2'h0, 0, 0);
    chk(r[7:0], d, "global_byte");
    io(1, 0, 8'hf4);
    io(1, 1, d);
    io(0, 1, 8'h00);
    chk(q, 8'hff, "undefined_read");
    io(1, 0, 8'haa);
    chk(in_config, 0, "in_config");
    for (int i = 0; i < 9; i++) begin
        w = $urandom;
        ec(1, 24'hff3340 + 24'(16 * (i % 3 + i % 3 / 2)), 2'(i / 3), w,
           i / 3 > i % 3);
    end
    ec(0, 24'hff3370, 2'h2, 0, 0);
    chk(r, w, "word_readback");
    foreach (bad[k]) ec(0, bad[k][23:0], 2'h0, 0, bad[k][24]);
    ec(1, 24'hff3384, 2'h2, 32'hffffffff, 0);
    ec(0, 24'hff3384, 2'h2, 0, 0);
    chk(r, 32'h80000000, "global_bar");
    ec(1, 24'hff3360, 2'h2, 32'h8000004e, 0);
    base = 16'h004e;
    io(1, 0, 8'h55);
    chk(in_config, 1, "moved_port");
    conclude();
end
endmodule // tb_top
